// file: inc/pcs_pkg.sv
// Package for the program counter sequencing unit: widths, sizes, operation codes.
// Assumes a single core clock domain and an active-low asynchronous reset.
`default_nettype none
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 5;
  localparam int JMP_W = 11;
  localparam int PAGE_W = 2;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [HIGH_W-1:0] LATCH_RESET = 5'h00;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;

  // One operation per instruction cycle, chosen by the decoder
  typedef enum logic [2:0] {
    PCS_OP_HOLD,
    PCS_OP_NEXT,
    PCS_OP_JUMP,
    PCS_OP_CALL,
    PCS_OP_VECTOR,
    PCS_OP_RETURN,
    PCS_OP_RET_LIT,
    PCS_OP_RET_INT
  } pcs_op_t;
endpackage : pcs_pkg
`default_nettype wire

// file: inc/pcs_stack_if.sv
// Interface between the counter logic and the return stack.
// Assumes both ends sit on the same core clock.
`default_nettype none
interface pcs_stack_if;
  import pcs_pkg::*;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  logic [PC_W-1:0] top;
  modport ctrl(output push, output pop, output push_data, input top);
  modport stack(input push, input pop, input push_data, output top);
endinterface : pcs_stack_if
`default_nettype wire

// file: src/pcs_return_stack.sv
// Circular eight-entry return stack of full program counter values.
// Assumes push and pop never come in the same cycle.
`default_nettype none
module pcs_return_stack (
  input wire logic clk_in,
  input wire logic arst_n_in,
  pcs_stack_if.stack stk
);
  import pcs_pkg::*;

  typedef struct packed {
    logic [STK_DEPTH-1:0][PC_W-1:0] mem;
    logic [SP_W-1:0] sp;
  } pcs_stk_state_t;

  pcs_stk_state_t st;
  pcs_stk_state_t next_st;

  // Pointer wraps silently both ways; no overflow flag exists
  always_comb begin
    next_st = st;
    if (stk.push) begin
      next_st.mem[st.sp] = stk.push_data;
      next_st.sp = st.sp + SP_ONE;
    end else if (stk.pop) begin
      next_st.sp = st.sp - SP_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Top entry is the one most recently pushed
  assign stk.top = st.mem[st.sp - SP_ONE];

  AST_WRAP_OVERWRITE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    stk.push |=> st.mem[$past(st.sp)] == $past(stk.push_data))
    else $error("push did not land at pointer slot");
  AST_POP_SILENT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    stk.pop && !stk.push |=> st.sp == $past(st.sp) - SP_ONE && st.mem == $past(st.mem))
    else $error("pop changed stack contents");
endmodule : pcs_return_stack
`default_nettype wire

// file: src/pcs_program_counter.sv
// Program counter sequencing unit: 13-bit counter, staging latch, page loads, stack.
// Assumes the decoder issues one operation per instruction-cycle enable.
`default_nettype none
module pcs_program_counter (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic cycle_en_in,
  input wire pcs_pkg::pcs_op_t op_in,
  input wire logic [pcs_pkg::JMP_W-1:0] operand_in,
  input wire logic low_wr_in,
  input wire logic [pcs_pkg::LOW_W-1:0] low_wdata_in,
  input wire logic latch_wr_in,
  input wire logic [pcs_pkg::LOW_W-1:0] latch_wdata_in,
  output logic [pcs_pkg::PC_W-1:0] pc_out,
  output logic [pcs_pkg::LOW_W-1:0] pc_low_byte_reg_out,
  output logic [pcs_pkg::LOW_W-1:0] pc_upper_staging_latch_out
);
  import pcs_pkg::*;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [HIGH_W-1:0] pc_upper_staging_latch;
  } pcs_state_t;

  pcs_state_t st;
  pcs_state_t next_st;
  pcs_stack_if stk_bus ();

  // Page-relative target for jumps and calls
  function automatic logic [PC_W-1:0] page_target(input logic [HIGH_W-1:0] latch,
                                                  input logic [JMP_W-1:0] opnd);
    page_target = {latch[HIGH_W-1:HIGH_W-PAGE_W], opnd};
  endfunction : page_target

  // Address after the current word; wraps at the top of the 8K space
  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
    pc_inc = pc + PC_ONE;
  endfunction : pc_inc

  // Stack requests; the pointer itself never reaches a port
  always_comb begin
    stk_bus.push = cycle_en_in && (op_in == PCS_OP_CALL || op_in == PCS_OP_VECTOR);
    stk_bus.pop = cycle_en_in && (op_in == PCS_OP_RETURN || op_in == PCS_OP_RET_LIT
                  || op_in == PCS_OP_RET_INT);
    stk_bus.push_data = pc_inc(st.pc);
  end

  // Next counter and latch; a low-byte write outranks the sequencer
  always_comb begin
    next_st = st;
    if (latch_wr_in) begin
      next_st.pc_upper_staging_latch = latch_wdata_in[HIGH_W-1:0];
    end
    if (low_wr_in) begin
      next_st.pc = {st.pc_upper_staging_latch, low_wdata_in};
    end else if (cycle_en_in) begin
      case (op_in)
        PCS_OP_NEXT: next_st.pc = pc_inc(st.pc);
        PCS_OP_JUMP,
        PCS_OP_CALL: next_st.pc = page_target(st.pc_upper_staging_latch, operand_in);
        PCS_OP_VECTOR: next_st.pc = INT_VECTOR;
        PCS_OP_RETURN,
        PCS_OP_RET_LIT,
        PCS_OP_RET_INT: next_st.pc = stk_bus.top;
        default: next_st.pc = st.pc;
      endcase
    end
  end

  // Reset clears the whole counter, upper bits included
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st.pc <= PC_RESET;
      st.pc_upper_staging_latch <= LATCH_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops; upper bits never show in the low-byte view
  assign pc_out = st.pc;
  assign pc_low_byte_reg_out = st.pc[LOW_W-1:0];
  assign pc_upper_staging_latch_out = {{(LOW_W-HIGH_W){1'b0}}, st.pc_upper_staging_latch};

  pcs_return_stack u_stack (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .stk(stk_bus.stack)
  );

  AST_LOW_WRITE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    low_wr_in |=> pc_out == {$past(st.pc_upper_staging_latch), $past(low_wdata_in)})
    else $error("low byte write did not load counter");
  AST_JUMP_PAGE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    cycle_en_in && !low_wr_in && op_in == PCS_OP_JUMP
    |=> pc_out[JMP_W-1:0] == $past(operand_in)
        && pc_out[PC_W-1:JMP_W] == $past(st.pc_upper_staging_latch[HIGH_W-1:HIGH_W-PAGE_W]))
    else $error("jump page wrong");
  AST_INCREMENT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    cycle_en_in && !low_wr_in && op_in == PCS_OP_NEXT |=> pc_out == $past(pc_out) + PC_ONE)
    else $error("sequential fetch did not increment");
  AST_CALL_RETURN: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    cycle_en_in && !low_wr_in && op_in == PCS_OP_CALL
    ##1 (cycle_en_in && !low_wr_in && op_in == PCS_OP_RETURN)
    |=> pc_out == $past(pc_out, 2) + PC_ONE)
    else $error("return did not restore full counter");
  AST_LATCH_KEPT: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !latch_wr_in && (stk_bus.push || stk_bus.pop)
    |=> $stable(pc_upper_staging_latch_out))
    else $error("stack op changed latch");
  AST_PUSH_CAUSE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    stk_bus.push |-> cycle_en_in && (op_in == PCS_OP_CALL || op_in == PCS_OP_VECTOR))
    else $error("push without call or vector");
  AST_VECTOR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    cycle_en_in && !low_wr_in && op_in == PCS_OP_VECTOR |=> pc_out == INT_VECTOR)
    else $error("vector not taken");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    !cycle_en_in && !low_wr_in |=> $stable(pc_out))
    else $error("counter moved without enable");
endmodule : pcs_program_counter
`default_nettype wire

// file: verification/pcs_decoder_model.sv
// Behavioural model of the core decoder issuing one operation per enable.
// Assumes a free-running core clock; drives only on falling edges.
`default_nettype none
module pcs_decoder_model (
  input wire logic clk_in,
  output logic cycle_en_out,
  output pcs_pkg::pcs_op_t op_out,
  output logic [pcs_pkg::JMP_W-1:0] operand_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  // Idle until the first operation
  initial begin
    cycle_en_out = 1'b0;
    op_out = PCS_OP_HOLD;
    operand_out = 11'h000;
  end
  // One enabled cycle; operand inverted on release so stale bits never match
  task automatic issue(input pcs_op_t o, input logic [JMP_W-1:0] a);
    @(negedge clk_in);
    cycle_en_out <= 1'b1;
    op_out <= o;
    operand_out <= a;
    @(negedge clk_in);
    cycle_en_out <= 1'b0;
    operand_out <= ~a;
  endtask : issue
endmodule : pcs_decoder_model
`default_nettype wire

// file: verification/pcs_program_counter_tb.sv
// Self-checking bench for the program counter sequencing unit.
// Assumes the decoder model drives operations; bench plays the software side.
`default_nettype none
module pcs_program_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic clk_in = 1'b0, arst_n_in = 1'b0, low_wr_in = 1'b0, latch_wr_in = 1'b0, cycle_en;
  logic [7:0] low_wdata_in = 8'h00, latch_wdata_in = 8'h00, low_o, lat_o;
  logic [10:0] opnd;
  logic [12:0] pc_o, pc, stk [8];
  logic [4:0] lat;
  logic [2:0] sp;
  logic [31:0] seed = 32'h25;
  pcs_op_t op;
  logic [12:0] exp_q [$];
  int bad_count = 0, tests_run = 0;
  pcs_decoder_model dec_i (.clk_in(clk_in), .cycle_en_out(cycle_en), .op_out(op),
    .operand_out(opnd));
  pcs_program_counter pcs_program_counter_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .cycle_en_in(cycle_en), .op_in(op), .operand_in(opnd), .low_wr_in(low_wr_in),
    .low_wdata_in(low_wdata_in), .latch_wr_in(latch_wr_in), .latch_wdata_in(latch_wdata_in),
    .pc_out(pc_o), .pc_low_byte_reg_out(low_o), .pc_upper_staging_latch_out(lat_o));
  // 50 MHz core clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Counter, low byte and latch seen together; upper latch bits read zero
  task automatic cmp(input logic [12:0] e);
    tests_run++;
    if ({lat_o, low_o, pc_o} !== {3'h0, lat, e[7:0], e}) begin
      $display("wrong value at %0t: got %h expected %h", $time, {lat_o, low_o, pc_o},
        {3'h0, lat, e[7:0], e});
      bad_count++;
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // Reference model updated ahead of each operation
  task automatic do_op(input pcs_op_t o, input logic [10:0] a);
    case (o)
      PCS_OP_HOLD: ;
      PCS_OP_NEXT: pc = pc + 13'h0001;
      PCS_OP_JUMP: pc = {lat[4:3], a};
      PCS_OP_CALL, PCS_OP_VECTOR: begin
        stk[sp] = pc + 13'h0001;
        sp++;
        pc = (o == PCS_OP_CALL) ? {lat[4:3], a} : INT_VECTOR;
      end
      default: begin
        sp--;
        pc = stk[sp];
      end
    endcase
    exp_q.push_back(pc);
    dec_i.issue(o, a);
  endtask : do_op
  task automatic wr(input logic is_low, input logic [7:0] d);
    @(negedge clk_in);
    if (is_low) begin
      pc = {lat, d};
      exp_q.push_back(pc);
      low_wr_in <= 1'b1;
      low_wdata_in <= d;
    end else begin
      latch_wr_in <= 1'b1;
      latch_wdata_in <= d;
    end
    @(negedge clk_in);
    {low_wr_in, latch_wr_in} <= 2'b00;
    if (!is_low) lat = d[4:0];
  endtask : wr
  task automatic do_reset();
    @(negedge clk_in);
    arst_n_in <= 1'b0;
    {pc, lat, sp} = '0;
    repeat (2) @(negedge clk_in);
    cmp(13'h0000);
    arst_n_in <= 1'b1;
  endtask : do_reset
  // Watcher: every taken operation or low-byte write is checked against the next expected counter value, unchanged for a hold
  always @(posedge clk_in) begin
    if (cycle_en === 1'b1 || low_wr_in === 1'b1) begin
      @(negedge clk_in);
      if (exp_q.size() == 0) bad_count++;
      else cmp(exp_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    do_reset();
    wr(1'b0, 8'hFA);
    wr(1'b1, 8'hFF);
    do_op(PCS_OP_NEXT, 11'h000);
    do_op(PCS_OP_HOLD, 11'h7FF);
    $display("test carry done");
    for (int p = 0; p < 4; p++) begin
      wr(1'b0, {3'h0, p[1:0], 3'h0} ^ {5'h0, rnd()} & 8'hE7);
      do_op(PCS_OP_JUMP, rnd());
    end
    $display("test pages done");
    for (int i = 0; i < 10; i++) do_op(i == 9 ? PCS_OP_VECTOR : PCS_OP_CALL, rnd());
    for (int i = 0; i < 10; i++) do_op(pcs_op_t'(PCS_OP_RETURN + i % 3), rnd());
    $display("test stack done");
    do_reset();
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge clk_in);
    tally_and_finish();
  end
endmodule : pcs_program_counter_tb
`default_nettype wire
